// ==== src/tsc_cfg.svh ====
// Register offsets, field positions, reset values and fixed codes of the touch register bank
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

`define TSC_OFS_FILTER      8'h56
`define TSC_OFS_SLOT0       8'h5c
`define TSC_OFS_SLOT1       8'h5d
`define TSC_OFS_THRESH0     8'h66
`define TSC_OFS_THRESH1     8'h67
`define TSC_OFS_CURRENT0    8'h70
`define TSC_OFS_CURRENT1    8'h71
`define TSC_OFS_LOCK        8'h79
`define TSC_OFS_PART        8'h7a
`define TSC_OFS_CONDITION   8'h7b
`define TSC_OFS_ADDRESS     8'h7c

`define TSC_BIT_BASE_RST    7
`define TSC_BIT_BUS_DROP    5
`define TSC_BIT_AVG_EN      4

`define TSC_RST_BUS_DROP    1'h1
`define TSC_RST_SLOT0       1'h0
`define TSC_RST_SLOT1       1'h1
`define TSC_RST_THRESH      8'h64
`define TSC_RST_CURRENT     8'h0a
`define TSC_RST_LOCK        1'h0

`define TSC_UNLOCK_B0       8'h3c
`define TSC_UNLOCK_B1       8'ha5
`define TSC_UNLOCK_B2       8'h69
`define TSC_LOCK_B0         8'h96
`define TSC_LOCK_B1         8'h5a
`define TSC_LOCK_B2         8'hc3

// Part codes: arbitrary neutral values
`define TSC_PART_ONE        8'ha1
`define TSC_PART_TWO        8'ha2

`endif

// ==== src/tsc_pkg.sv ====
// Types shared by the touch register bank and its surroundings
package tsc_pkg;

  typedef struct packed {
    logic       baseline_reset_all;
    logic       bus_activity_sample_drop;
    logic       average_filter_enable;
    logic [1:0] average_depth_select;
  } tsc_filter_t;

  typedef struct packed {
    logic [1:0] supply_level_code;
    logic       internal_reset_flag;
    logic       factory_defaults_loaded;
    logic       store_inhibit_low_supply;
    logic       sensing_enabled;
    logic       output_block_enabled;
  } tsc_condition_t;

  typedef enum logic [1:0] {
    TSC_SEQ_IDLE,
    TSC_SEQ_ONE,
    TSC_SEQ_TWO
  } tsc_seq_t;

endpackage

// ==== src/tsc_regs.sv ====
// Configuration and status register bank of the capacitive touch controller
//
// Summary of operation
// - Writing one to baseline_reset_all resets all baselines; the bit self-clears.
// - bus_activity_sample_drop, reset one, discards samples scanned during bus traffic.
// - average_filter_enable turns raw-count averaging on; zero passes samples straight.
// - average_depth_select 00/01/10/11 averages 2/4/8/16 samples.
// - scan_slot bit 0 sets scan order, setup-mode writes only, slot 1 resets one.
// - Each input has its own touch_threshold, reset 64 hex, valid 3 to 255; values 0 to 2 are stored as written.
// - sense_current_setting takes 1 to 255; writing zero stores default 10.
// - Bytes 3C, A5, 69 to the lock register unlock address changes.
// - Bytes 96, 5A, C3 to the lock register lock address changes.
// - Address register writes are ignored while address access is locked.
// - A new address is used for matching only after locking again.
// - Lock register bit 0 reads address_lock_state, 0 unlocked, 1 locked, reset 0.
// - Read-only part_code tells the one-button variant from the two-button one.
// - Status bits 7:6 give supply level: 00 5 V, 01 3.3 V, 10 2.7 V.
// - Status bit 5 reads one when the last reset was internally generated.
// - Status bit 4 shows whether factory defaults were loaded at power-up.
// - factory_defaults_loaded reads 0 for user, 1 for factory configuration.
// - store_inhibit_low_supply reads one when supply is too low to store.
// - sensing_enabled reads 1 while capacitive sensing is active.
// - output_block_enabled reads 1 while the digital output block is active.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module tsc_regs (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  // Byte register port from the serial slave engine
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // Device state
  input  wire logic                    setup_mode,
  input  wire logic                    two_button,
  input  wire logic                    bus_busy,
  input  wire tsc_pkg::tsc_condition_t condition,
  // Raw scan samples in, filtered counts out
  input  wire logic                    sample_valid,
  input  wire logic [15:0]             sample_raw,
  output logic                         count_valid,
  output logic      [15:0]             count_value,
  // Configuration to the sensing core
  output logic                         baseline_reset_pulse,
  output logic      [1:0]              scan_slot,
  output logic      [7:0]              touch_threshold_0,
  output logic      [7:0]              touch_threshold_1,
  output logic      [7:0]              sense_current_0,
  output logic      [7:0]              sense_current_1,
  // Slave address update
  output logic                         address_lock_state,
  output logic                         address_write,
  output logic      [7:0]              address_data,
  output logic                         address_commit
);

  // Number of samples per average for a depth code
  function automatic logic [4:0] avg_len(input logic [1:0] depth);
    avg_len = 5'h02 << depth;
  endfunction

  // Zero is not a legal current, so it falls back to the default
  function automatic logic [7:0] current_fix(input logic [7:0] value);
    current_fix = (value == 8'h00) ? `TSC_RST_CURRENT : value;
  endfunction

  tsc_pkg::tsc_filter_t filter;
  tsc_pkg::tsc_seq_t    seq_step;
  logic                 seq_unlock;
  logic                 scan_busy;
  logic [19:0]          avg_sum;
  logic [4:0]           avg_cnt;

  // Write decode
  wire wr_filter  = reg_wr && (reg_addr == `TSC_OFS_FILTER);
  wire wr_slot0   = reg_wr && (reg_addr == `TSC_OFS_SLOT0) && setup_mode;
  wire wr_slot1   = reg_wr && (reg_addr == `TSC_OFS_SLOT1) && setup_mode && two_button;
  wire wr_thr0    = reg_wr && (reg_addr == `TSC_OFS_THRESH0);
  wire wr_thr1    = reg_wr && (reg_addr == `TSC_OFS_THRESH1) && two_button;
  wire wr_cur0    = reg_wr && (reg_addr == `TSC_OFS_CURRENT0);
  wire wr_cur1    = reg_wr && (reg_addr == `TSC_OFS_CURRENT1) && two_button;
  wire wr_lock    = reg_wr && (reg_addr == `TSC_OFS_LOCK);
  wire wr_address = reg_wr && (reg_addr == `TSC_OFS_ADDRESS) && !address_lock_state;

  // Lock sequencer decode
  wire is_unlock0 = reg_wdata == `TSC_UNLOCK_B0;
  wire is_lock0   = reg_wdata == `TSC_LOCK_B0;
  wire mid_ok     = reg_wdata == (seq_unlock ? `TSC_UNLOCK_B1 : `TSC_LOCK_B1);
  wire end_ok     = reg_wdata == (seq_unlock ? `TSC_UNLOCK_B2 : `TSC_LOCK_B2);
  wire seq_done   = wr_lock && (seq_step == tsc_pkg::TSC_SEQ_TWO) && end_ok;
  wire seq_start  = is_unlock0 || is_lock0;

  tsc_pkg::tsc_seq_t next_seq_step;
  always_comb
  begin
    next_seq_step = seq_step;
    if (wr_lock)
    begin
      case (seq_step)
        tsc_pkg::TSC_SEQ_IDLE: next_seq_step = seq_start ? tsc_pkg::TSC_SEQ_ONE
                                                         : tsc_pkg::TSC_SEQ_IDLE;
        tsc_pkg::TSC_SEQ_ONE:  next_seq_step = mid_ok ? tsc_pkg::TSC_SEQ_TWO
                                              : (seq_start ? tsc_pkg::TSC_SEQ_ONE
                                                           : tsc_pkg::TSC_SEQ_IDLE);
        // A wrong byte restarts, but may itself open a new sequence
        tsc_pkg::TSC_SEQ_TWO:  next_seq_step = (!end_ok && seq_start) ? tsc_pkg::TSC_SEQ_ONE
                                                                      : tsc_pkg::TSC_SEQ_IDLE;
        default:               next_seq_step = tsc_pkg::TSC_SEQ_IDLE;
      endcase
    end
  end

  wire restart_kind = wr_lock && seq_start &&
                      (next_seq_step == tsc_pkg::TSC_SEQ_ONE);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_step   <= tsc_pkg::TSC_SEQ_IDLE;
      seq_unlock <= 1'h0;
    end
    else
    begin
      seq_step <= next_seq_step;
      if (restart_kind)
        seq_unlock <= is_unlock0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      address_lock_state <= `TSC_RST_LOCK;
      address_commit     <= 1'h0;
    end
    else
    begin
      if (seq_done)
        address_lock_state <= !seq_unlock;
      // Staged address goes live only when a lock completes
      address_commit <= seq_done && !seq_unlock;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      address_write <= 1'h0;
      address_data  <= 8'h00;
    end
    else
    begin
      address_write <= wr_address;
      if (wr_address)
        address_data <= reg_wdata;
    end
  end

  // Filter control; bit 7 holds for one cycle then clears itself
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      filter               <= '{1'h0, `TSC_RST_BUS_DROP, 1'h0, 2'h0};
      baseline_reset_pulse <= 1'h0;
    end
    else
    begin
      filter.baseline_reset_all <= wr_filter && reg_wdata[`TSC_BIT_BASE_RST];
      baseline_reset_pulse      <= wr_filter && reg_wdata[`TSC_BIT_BASE_RST];
      if (wr_filter)
      begin
        filter.bus_activity_sample_drop <= reg_wdata[`TSC_BIT_BUS_DROP];
        filter.average_filter_enable    <= reg_wdata[`TSC_BIT_AVG_EN];
        filter.average_depth_select     <= reg_wdata[1:0];
      end
    end
  end

  // Per-input settings
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_slot         <= {`TSC_RST_SLOT1, `TSC_RST_SLOT0};
      touch_threshold_0 <= `TSC_RST_THRESH;
      touch_threshold_1 <= `TSC_RST_THRESH;
      sense_current_0   <= `TSC_RST_CURRENT;
      sense_current_1   <= `TSC_RST_CURRENT;
    end
    else
    begin
      // Outside setup mode the slot writes fall away
      if (wr_slot0)
        scan_slot[0] <= reg_wdata[0];
      if (wr_slot1)
        scan_slot[1] <= reg_wdata[0];
      if (wr_thr0)
        touch_threshold_0 <= reg_wdata;
      if (wr_thr1)
        touch_threshold_1 <= reg_wdata;
      if (wr_cur0)
        sense_current_0 <= current_fix(reg_wdata);
      if (wr_cur1)
        sense_current_1 <= current_fix(reg_wdata);
    end
  end

  // Sample filter: bus traffic seen at any point of a scan taints it
  wire sample_drop = filter.bus_activity_sample_drop && (scan_busy || bus_busy);
  wire sample_take = sample_valid && !sample_drop;
  wire [4:0]  avg_target = avg_len(filter.average_depth_select);
  wire [19:0] avg_next   = avg_sum + {4'h0, sample_raw};
  wire        avg_full   = (avg_cnt + 5'h01) == avg_target;
  // Shift is one wider than the code so depth 11 reaches a shift of four
  wire [19:0] avg_mean   = avg_next >> ({1'h0, filter.average_depth_select} + 3'h1);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_busy   <= 1'h0;
      avg_sum     <= 20'h00000;
      avg_cnt     <= 5'h00;
      count_valid <= 1'h0;
      count_value <= 16'h0000;
    end
    else
    begin
      scan_busy   <= sample_valid ? 1'h0 : (scan_busy || bus_busy);
      count_valid <= 1'h0;
      // A config change restarts the running average
      if (wr_filter || !filter.average_filter_enable)
      begin
        avg_sum <= 20'h00000;
        avg_cnt <= 5'h00;
      end
      if (sample_take && !filter.average_filter_enable)
      begin
        count_valid <= 1'h1;
        count_value <= sample_raw;
      end
      else if (sample_take && !wr_filter)
      begin
        avg_sum <= avg_full ? 20'h00000 : avg_next;
        avg_cnt <= avg_full ? 5'h00 : avg_cnt + 5'h01;
        if (avg_full)
        begin
          count_valid <= 1'h1;
          count_value <= avg_mean[15:0];
        end
      end
    end
  end

  // Read mux; unmapped and absent registers read zero
  wire [7:0] part_code = two_button ? `TSC_PART_TWO : `TSC_PART_ONE;
  wire [7:0] cond_byte = {condition.supply_level_code,
                          condition.internal_reset_flag,
                          condition.factory_defaults_loaded,
                          condition.store_inhibit_low_supply,
                          1'h0,
                          condition.sensing_enabled,
                          condition.output_block_enabled};
  wire [7:0] filt_byte = {filter.baseline_reset_all, 1'h0,
                          filter.bus_activity_sample_drop,
                          filter.average_filter_enable, 2'h0,
                          filter.average_depth_select};

  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_addr)
      `TSC_OFS_FILTER:    next_rdata = filt_byte;
      `TSC_OFS_SLOT0:     next_rdata = {7'h00, scan_slot[0]};
      `TSC_OFS_SLOT1:     next_rdata = two_button ? {7'h00, scan_slot[1]} : 8'h00;
      `TSC_OFS_THRESH0:   next_rdata = touch_threshold_0;
      `TSC_OFS_THRESH1:   next_rdata = two_button ? touch_threshold_1 : 8'h00;
      `TSC_OFS_CURRENT0:  next_rdata = sense_current_0;
      `TSC_OFS_CURRENT1:  next_rdata = two_button ? sense_current_1 : 8'h00;
      `TSC_OFS_LOCK:      next_rdata = {7'h00, address_lock_state};
      `TSC_OFS_PART:      next_rdata = part_code;
      `TSC_OFS_CONDITION: next_rdata = cond_byte;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule // tsc_regs

// ==== testbench/testbench.sv ====
// Self-checking bench for the touch register bank
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_b = 1'b0, setup_mode = 1'b0, two_button = 1'b1, bus_busy = 1'b0;
  logic sample_valid = 1'b0, cv;
  logic [15:0] sample_raw = 16'h0000, lf = 16'h0037, v, cval;
  logic [19:0] sum;
  logic [7:0] d, t0, t1, c;
  tsc_pkg::tsc_condition_t condition = '0;
  wire logic reg_wr, reg_rd, count_valid, baseline_reset_pulse;
  wire logic address_lock_state, address_write, address_commit;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata, address_data;
  wire logic [7:0] touch_threshold_0, touch_threshold_1, sense_current_0, sense_current_1;
  wire logic [15:0] count_value;
  wire logic [1:0] scan_slot;
  int miscompares = 0, checked = 0;
  logic [7:0] ra [9] = '{8'h56, 8'h5c, 8'h5d, 8'h66, 8'h67, 8'h70, 8'h71, 8'h79, 8'h7a};
  logic [7:0] rv [9] = '{8'h20, 8'h00, 8'h01, 8'h64, 8'h64, 8'h0a, 8'h0a, 8'h00, 8'ha2};
  always #20 ref_clk = ~ref_clk;
  tsc_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  tsc_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .setup_mode(setup_mode), .two_button(two_button), .bus_busy(bus_busy),
    .condition(condition), .sample_valid(sample_valid), .sample_raw(sample_raw),
    .count_valid(count_valid), .count_value(count_value),
    .baseline_reset_pulse(baseline_reset_pulse), .scan_slot(scan_slot),
    .touch_threshold_0(touch_threshold_0), .touch_threshold_1(touch_threshold_1),
    .sense_current_0(sense_current_0), .sense_current_1(sense_current_1),
    .address_lock_state(address_lock_state), .address_write(address_write),
    .address_data(address_data), .address_commit(address_commit));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [7:0] cur_exp(input logic [7:0] w);
    return (w == 8'h00) ? 8'h0a : w;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic smp(input logic [15:0] x);
    @(posedge ref_clk);
    #1;
    sample_valid = 1'b1;
    sample_raw   = x;
    @(posedge ref_clk);
    #1;
    sample_valid = 1'b0;
    sample_raw   = ~x;
    cv   = count_valid;
    cval = count_value;
  endtask
  task automatic seq3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    host.wr(8'h79, b0);
    host.wr(8'h79, b1);
    host.wr(8'h79, b2);
    host.idle();
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    chk("slot port", scan_slot, 2'b10);
    foreach (ra[i]) begin host.rd(ra[i], d); chk("reset value", d, rv[i]); end
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      condition = {i[1:0], v[1:0], v[4], v[3:2]};
      host.rd(8'h7b, d);
      chk("status", d, {i[1:0], v[1:0], v[4], 1'b0, v[3:2]});
    end
    host.wr(8'h7a, 8'hff);
    host.wr(8'h40, 8'hff);
    host.rd(8'h7a, d);
    chk("part after write", d, 8'ha2);
    host.rd(8'h40, d);
    chk("unmapped", d, 8'h00);
    two_button = 1'b0;
    host.rd(8'h7a, d);
    chk("one button part", d, 8'ha1);
    host.rd(8'h71, d);
    chk("one button current", d, 8'h00);
    two_button = 1'b1;
    host.wr(8'h56, 8'h80);
    host.idle();
    chk("baseline pulse", baseline_reset_pulse, 1'b1);
    host.rd(8'h56, d);
    chk("filter self clear", {baseline_reset_pulse, d}, 9'h000);
    host.wr(8'h07, 8'h00);
    host.wr(8'h50, 8'h00);
    host.wr(8'h51, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      setup_mode = s[0];
      host.wr(8'h5c, 8'h01);
      host.wr(8'h5d, 8'h00);
      host.idle();
      chk("slots", scan_slot, s ? 2'b01 : 2'b10);
    end
    setup_mode = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      t0 = rnd() | 8'h04;
      t1 = rnd() | 8'h04;
      c  = (k == 0) ? 8'h00 : (rnd() | 8'h08);
      host.wr(8'h66, t0);
      host.wr(8'h67, t1);
      host.wr(8'h70, c);
      host.wr(8'h71, ~c);
      host.rd(8'h71, d);
      chk("thresholds", {touch_threshold_0, touch_threshold_1}, {t0, t1});
      chk("currents", {sense_current_0, sense_current_1, d}, {cur_exp(c), cur_exp(~c), cur_exp(~c)});
    end
    host.wr(8'h7c, 8'h2a);
    host.idle();
    chk("staged address", {address_write, address_data}, 9'h12a);
    seq3(8'h96, 8'h5a, 8'hc3);
    chk("lock commit", {address_lock_state, address_commit}, 2'b11);
    host.rd(8'h79, d);
    chk("lock read", d, 8'h01);
    host.wr(8'h7c, 8'h55);
    host.idle();
    chk("locked address", address_write, 1'b0);
    host.wr(8'h79, 8'h3c);
    seq3(8'ha5, 8'h00, 8'h69);
    chk("broken unlock", address_lock_state, 1'b1);
    host.wr(8'h79, 8'h3c);
    host.wr(8'h40, 8'h00);
    seq3(8'ha5, 8'h69, 8'h00);
    chk("unlock", address_lock_state, 1'b0);
    host.wr(8'h56, 8'h00);
    host.idle();
    v = rnd();
    smp(v);
    chk("plain count", {cv, cval}, {1'b1, v});
    for (int dp = 0; dp < 4; dp++)
    begin
      host.wr(8'h56, 8'h10 | dp[7:0]);
      host.idle();
      sum = '0;
      for (int n = 0; n < (2 << dp); n++)
      begin
        v = rnd();
        sum += v;
        smp(v);
        chk("average strobe", cv, n == (2 << dp) - 1);
      end
      chk("average", cval, sum >> (dp + 1));
    end
    host.wr(8'h56, 8'h20);
    host.idle();
    bus_busy = 1'b1;
    smp(v);
    bus_busy = 1'b0;
    chk("dropped sample", cv, 1'b0);
    smp(v);
    smp(~v);
    chk("clean sample", {cv, cval}, {1'b1, ~v});
    host.wr(8'h56, 8'h00);
    host.idle();
    bus_busy = 1'b1;
    smp(v);
    bus_busy = 1'b0;
    chk("kept sample", {cv, cval}, {1'b1, v});
    seq3(8'h96, 8'h5a, 8'hc3);
    chk("relock", {address_lock_state, address_commit, address_data}, 10'h32a);
    seq3(8'h3c, 8'ha5, 8'h69);
    chk("direct unlock", {address_lock_state, address_commit}, 2'b00);
    print_verdict();
  end
endmodule // testbench

// ==== testbench/tsc_host_model.sv ====
// Host model driving the byte register port
`timescale 1ns/1ps
module tsc_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe stays up across back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_rd    = 1'b0;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
  endtask
  // Released lines flip so stale values never look valid
  task automatic idle();
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr   = 1'b0;
    reg_rd   = 1'b1;
    reg_addr = a;
    idle();
    d = reg_rdata;
  endtask
endmodule // tsc_host_model

// ==== testbench/tsc_regs_sva.sv ====
// Concurrent checks on the ports of the touch register bank
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tsc_regs_sva (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Device state
  input wire logic       setup_mode,
  input wire logic       two_button,
  // Watched outputs
  input wire logic       baseline_reset_pulse,
  input wire logic [1:0] scan_slot,
  input wire logic [7:0] sense_current_0,
  input wire logic       address_lock_state,
  input wire logic       address_write,
  input wire logic [7:0] address_data,
  input wire logic       address_commit,
  input wire logic       count_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic wr_filt = reg_wr && reg_addr == `TSC_OFS_FILTER;
  wire logic wr_adr  = reg_wr && reg_addr == `TSC_OFS_ADDRESS;
  wire logic wr_slot = reg_wr && reg_addr == `TSC_OFS_SLOT0;
  wire logic wr_cur  = reg_wr && reg_addr == `TSC_OFS_CURRENT0;
  sequence lk(b);
    reg_wr && reg_addr == `TSC_OFS_LOCK && reg_wdata == b;
  endsequence
  AST_BASE_PULSE: assert property (wr_filt && reg_wdata[7] |=> baseline_reset_pulse)
    else $error("baseline reset pulse missing");
  AST_PULSE_ONE: assert property (baseline_reset_pulse && !(wr_filt && reg_wdata[7]) |=>
    !baseline_reset_pulse)
    else $error("baseline reset pulse too long");
  AST_UNLOCK: assert property (lk(8'h3c) ##1 lk(8'ha5) ##1 lk(8'h69) |=> !address_lock_state)
    else $error("unlock sequence ignored");
  AST_LOCK: assert property (lk(8'h96) ##1 lk(8'h5a) ##1 lk(8'hc3) |=> address_lock_state)
    else $error("lock sequence ignored");
  AST_ADDR_SHUT: assert property (wr_adr && address_lock_state |=> !address_write)
    else $error("address write accepted while locked");
  AST_ADDR_OPEN: assert property (wr_adr && !address_lock_state |=>
    address_write && address_data == $past(reg_wdata)) else $error("address write lost");
  AST_COMMIT: assert property (address_commit |-> $rose(address_lock_state))
    else $error("address committed without locking");
  AST_CUR_ZERO: assert property (wr_cur && reg_wdata == 8'h00 |=> sense_current_0 == 8'h0a)
    else $error("zero current not replaced");
  AST_SLOT_HOLD: assert property (wr_slot && !setup_mode |=> $stable(scan_slot[0]))
    else $error("slot changed outside setup");
  AST_SLOT_SET: assert property (wr_slot && setup_mode |=> scan_slot[0] == $past(reg_wdata[0]))
    else $error("slot not written in setup");
  AST_PART: assert property (reg_rd && reg_addr == `TSC_OFS_PART |=>
    reg_rdata == ($past(two_button) ? `TSC_PART_TWO : `TSC_PART_ONE)) else $error("bad part code");
  COV_UNLOCK: cover property (lk(8'h3c) ##1 lk(8'ha5) ##1 lk(8'h69));
  COV_COMMIT: cover property (address_commit);
  COV_COUNT: cover property (count_valid);
endmodule // tsc_regs_sva

bind tsc_regs tsc_regs_sva chk (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .setup_mode, .two_button, .baseline_reset_pulse, .scan_slot, .sense_current_0,
  .address_lock_state, .address_write, .address_data, .address_commit, .count_valid);
